/* File: two_wire_register_slave_bench.sv */
`timescale 1ns/10ps
module two_wire_register_slave_bench;
   import twrs_pkg::*;
   logic clk_i, rst_n_i, pin, cmd_valid, cmd_read, take, rvalid, done, nack, wr_stb;
   logic cmd_ready, busy, scl_p, sda_p;
   logic [6:0] cmd_dev, a0, a1;
   logic [7:0] cmd_reg, wdata, rdata, wr_data, first_b, sh, rb;
   logic [3:0] cmd_len;
   logic [PTR_W-1:0] wr_addr;
   int n_errors, checks_done, seed, nbit;
   int mem [0:30];
   int eq_a[$], eq_d[$], rq[$], wbuf[$];

   twrs_if bus();
   twrs_device u_twrs_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .address_select_pin_i(pin),
      .bus(bus), .wr_stb_o(wr_stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .busy_o(busy));
   twrs_host u_twrs_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus), .cmd_valid_i(cmd_valid),
      .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read), .cmd_dev_addr_i(cmd_dev),
      .cmd_reg_i(cmd_reg), .cmd_len_i(cmd_len), .wdata_i(wdata), .wdata_take_o(take),
      .rdata_o(rdata), .rdata_valid_o(rvalid), .done_o(done), .nack_o(nack));
   twrs_checker u_twrs_checker (.clk_i(clk_i), .rst_n_i(rst_n_i), .address_select_pin_i(pin),
      .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Reference model: saturating pointer over the register array
   task automatic xfer(input logic rd, input logic [6:0] dev, input logic [7:0] base,
                       input int len, input logic bad, input string name);
      int a;
      for (int i = 0; i < len && !bad; i++) begin
         a = (base + i > REG_COUNT - 1) ? REG_COUNT - 1 : base + i;
         if (rd) rq.push_back(mem[a]);
         else begin
            wbuf.push_back($random(seed) & 255);
            mem[a] = wbuf[i];
            eq_a.push_back(a);
            eq_d.push_back(wbuf[i]);
         end
      end
      @(negedge clk_i);
      while (cmd_ready !== 1'b1) @(negedge clk_i);
      cmd_read = rd;
      cmd_dev = dev;
      cmd_reg = base;
      cmd_len = 4'(len);
      cmd_valid = 1'b1;
      // Ready was seen settled high, so the next rising edge takes the command
      @(negedge clk_i);
      cmd_valid = 1'b0;
      do @(negedge clk_i); while (done !== 1'b1);
      chk(9'(nack), 9'(bad));
      chk({1'b0, first_b}, {1'b0, dev, rd & !bad});
      chk({6'h00, busy, bus.scl, bus.sda}, 9'h003);
      chk(9'(eq_a.size() + rq.size()), 9'h000);
      wbuf.delete();
      eq_a.delete();
      eq_d.delete();
      rq.delete();
      $display("test %s finished", name);
   endtask

   // Registered outputs are compared mid-cycle, where they are settled
   always @(negedge clk_i) begin
      if (wr_stb === 1'b1) begin
         chk(9'(wr_addr), eq_a.size() ? 9'(eq_a.pop_front()) : 9'h1FF);
         chk(9'(wr_data), eq_d.size() ? 9'(eq_d.pop_front()) : 9'h1FF);
      end
      if (rvalid === 1'b1) chk(9'(rdata), rq.size() ? 9'(rq.pop_front()) : 9'h1FF);
   end

   // Host captures write data at the rising edge that ends its take pulse
   always @(posedge clk_i) begin
      if (take === 1'b1 && wbuf.size() != 0) void'(wbuf.pop_front());
   end

   always @(negedge clk_i) wdata <= wbuf.size() ? 8'(wbuf[0]) : 8'h00;

   // Wire sniffer: first byte after every start, shifted in as sent
   always @(posedge clk_i) begin
      scl_p <= bus.scl;
      sda_p <= bus.sda;
      if (scl_p && bus.scl && sda_p && !bus.sda) nbit <= 0;
      else if (!scl_p && bus.scl) begin
         nbit <= nbit + 1;
         sh = {sh[6:0], bus.sda};
         if (nbit == 7) first_b <= sh;
      end
   end

   initial begin
      clk_i = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
   end

   initial begin
      repeat (95000) @(posedge clk_i);
      n_errors++;
      report_and_stop();
   end

   initial begin
      seed = 32296;
      rst_n_i = 1'b0;
      pin = 1'b0;
      cmd_valid = 1'b0;
      cmd_read = 1'b0;
      cmd_dev = 7'h00;
      cmd_reg = 8'h00;
      cmd_len = 4'h0;
      wdata = 8'h00;
      scl_p = 1'b1;
      sda_p = 1'b1;
      a0 = {DEV_ADDR_BASE[6:1], 1'b0};
      a1 = {DEV_ADDR_BASE[6:1], 1'b1};
      for (int i = 0; i < REG_COUNT; i++) mem[i] = REG_RESET;
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      xfer(1'b0, a0, 8'h05, 1, 1'b0, "single write");
      xfer(1'b1, a0, 8'h05, 1, 1'b0, "single read");
      xfer(1'b0, a0, REG_MAX - 8'h02, 4, 1'b0, "write past top");
      xfer(1'b1, a0, REG_MAX - 8'h02, 4, 1'b0, "read past top");
      xfer(1'b0, a0, REG_MAX + 8'h01, 2, 1'b1, "base above top");
      xfer(1'b1, a0, 8'hFF, 1, 1'b1, "read base above top");
      xfer(1'b0, a1, 8'h00, 1, 1'b1, "foreign address");
      @(negedge clk_i);
      pin = 1'b1;
      repeat (4) @(negedge clk_i);
      rb = 8'($random(seed) & 15);
      xfer(1'b0, a1, rb, 3, 1'b0, "second address write");
      xfer(1'b1, a1, rb, 3, 1'b0, "second address read");
      xfer(1'b1, a0, rb, 1, 1'b1, "first address refused");
      report_and_stop();
   end
endmodule

/* File: twrs_checker_sva.sv */
`timescale 1ns/10ps
module twrs_checker (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic address_select_pin_i,
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   import twrs_pkg::*;
   logic scl_q, sda_q, act_q, rw_q, ok_q, quiet_q, mnack_q;
   logic [3:0] bit_q;
   logic [1:0] byte_q;
   logic [7:0] sh_q;
   logic start_w, stop_w, slot_w, sack_w;
   assign start_w = scl_q && scl && sda_q && !sda;
   assign stop_w = scl_q && scl && !sda_q && sda;
   assign slot_w = act_q && !scl_q && scl && bit_q == 4'h8;
   // Slave owns the ack slot of the address byte and of every write byte
   assign sack_w = byte_q == 2'h0 || !rw_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // Bus decoder: bit and byte position since the last start
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act_q <= 1'b0;
         rw_q <= 1'b0;
         ok_q <= 1'b0;
         quiet_q <= 1'b0;
         mnack_q <= 1'b0;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         sh_q <= 8'h00;
      end else if (start_w) begin
         act_q <= 1'b1;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         quiet_q <= 1'b0;
         mnack_q <= 1'b0;
      end else if (stop_w) begin
         act_q <= 1'b0;
         quiet_q <= 1'b0;
         mnack_q <= 1'b0;
      end else if (act_q && !scl_q && scl) begin
         if (bit_q == 4'h8) begin
            bit_q <= 4'h0;
            byte_q <= (byte_q == 2'h3) ? byte_q : byte_q + 2'h1;
            if (byte_q == 2'h0) begin
               rw_q <= sh_q[0];
               ok_q <= !sda;
            end
            if (sda && sack_w) begin
               quiet_q <= 1'b1;
            end
            if (sda && !sack_w) begin
               mnack_q <= 1'b1;
            end
         end else begin
            sh_q <= {sh_q[6:0], sda};
            bit_q <= bit_q + 4'h1;
         end
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_addr_ack;
      slot_w && byte_q == 2'h0 |-> sda == (sh_q[7:1] != {DEV_ADDR_BASE[6:1], address_select_pin_i});
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
   property p_base_ack;
      slot_w && byte_q == 2'h1 && !rw_q && ok_q |-> sda == (sh_q > REG_MAX);
   endproperty
   a_base_ack: assert property (p_base_ack) else $error("base ack wrong");
   property p_quiet;
      quiet_q |-> !s_sda_oe;
   endproperty
   a_quiet: assert property (p_quiet) else $error("drive after own nack");
   property p_mnack;
      mnack_q |-> !s_sda_oe;
   endproperty
   a_mnack: assert property (p_mnack) else $error("drive after master nack");
   property p_idle;
      !act_q |-> !s_sda_oe;
   endproperty
   a_idle: assert property (p_idle) else $error("drive while idle");
   property p_low_only;
      s_sda_oe |-> !s_sda_o && !sda;
   endproperty
   a_low_only: assert property (p_low_only) else $error("data driven high");
   property p_change_low;
      $changed(s_sda_oe) |-> !scl;
   endproperty
   a_change_low: assert property (p_change_low) else $error("data moved, clock high");
   property p_ack_release;
      $fell(scl) && act_q && bit_q == 4'h0 && !rw_q |-> ##[1:8] !s_sda_oe;
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("ack held too long");

   c_wr_ack: cover property (slot_w && byte_q == 2'h2 && !rw_q && !sda);
   c_rstart: cover property (start_w && act_q);
   c_mnack: cover property (slot_w && !sack_w && sda);
   c_base_nack: cover property (slot_w && byte_q == 2'h1 && !rw_q && sda);
endmodule

/* File: twrs_device.sv */
// What this block does
// RULE1: Bytes travel most significant bit first.
// RULE2: Unacknowledged write leaves data line released high.
// RULE3: Master nack on read ends data, release line.
// RULE4: Byte after write address latches base address.
// RULE5: First write byte at base, then pointer increments.
// RULE6: Pointer saturates at top register 0x1E.
// RULE7: Base address above 0x1E is not acknowledged.
// RULE8: Master writes base, then restarts with read.
// RULE9: Read pointer advances after every transmitted byte.
// RULE10: Stop condition returns the slave to idle.
// RULE11: Repeated start begins a fresh address phase.
// RULE12: First byte is seven address bits plus direction.
// RULE13: Matching address acknowledged low on ninth clock.
// RULE14: Slave only pulls low, changes while clock low.
`timescale 1ns/10ps
module twrs_device (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic address_select_pin_i,
   twrs_if.dev bus,
   output logic wr_stb_o,
   output logic [twrs_pkg::PTR_W-1:0] wr_addr_o,
   output logic [7:0] wr_data_o,
   output logic busy_o
);
   import twrs_pkg::*;

   logic scl_s1_q;
   logic scl_s2_q;
   logic scl_s3_q;
   logic sda_s1_q;
   logic sda_s2_q;
   logic sda_s3_q;
   logic sel_s1_q;
   logic sel_s2_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [6:0] own_addr;

   twrs_dev_state_t state_q;
   twrs_kind_t kind_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic rw_q;
   logic mack_q;
   logic [PTR_W-1:0] ptr_q;
   logic sda_oe_q;
   logic wr_stb_q;
   logic [PTR_W-1:0] wr_addr_q;
   logic [7:0] wr_data_q;
   logic [7:0] mem_q [REG_COUNT];

   function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
      next_ptr = (p == REG_MAX[PTR_W-1:0]) ? p : p + 1'b1; // see RULE6
   endfunction

   // Pins are synchronised; the third stage is only the edge reference
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_s3_q <= 1'b1;
         sel_s1_q <= 1'b0;
         sel_s2_q <= 1'b0;
      end else begin
         scl_s1_q <= bus.scl;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= bus.sda;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
         sel_s1_q <= address_select_pin_i;
         sel_s2_q <= sel_s1_q;
      end
   end

   assign scl_rise = scl_s2_q && !scl_s3_q;
   assign scl_fall = !scl_s2_q && scl_s3_q;
   assign start_det = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
   assign stop_det = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q; // see RULE10
   assign own_addr = {DEV_ADDR_BASE[6:1], sel_s2_q}; // see RULE13

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= D_IDLE;
         kind_q <= K_ADDR;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
         ptr_q <= '0;
         sda_oe_q <= 1'b0;
         wr_stb_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= 8'h00;
      end else begin
         wr_stb_q <= 1'b0;
         if (start_det) begin
            // A start with no stop before it restarts the address phase
            state_q <= D_RX; // see RULE11
            kind_q <= K_ADDR;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
         end else if (stop_det) begin
            state_q <= D_IDLE; // see RULE10
            sda_oe_q <= 1'b0;
         end else begin
            unique case (state_q)
               D_IDLE, D_WAIT: begin
                  sda_oe_q <= 1'b0; // see RULE2
               end
               D_RX: begin
                  if (scl_rise) begin
                     sh_q <= {sh_q[6:0], sda_s2_q}; // see RULE1
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                     cnt_q <= 4'h0;
                     state_q <= D_ACK;
                     unique case (kind_q)
                        K_ADDR: begin
                           if (sh_q[7:1] == own_addr) begin // see RULE12
                              sda_oe_q <= 1'b1; // see RULE13
                              rw_q <= sh_q[0];
                              kind_q <= K_REG;
                           end else begin
                              state_q <= D_WAIT;
                           end
                        end
                        K_REG: begin
                           if (sh_q <= REG_MAX) begin // see RULE7
                              sda_oe_q <= 1'b1;
                              ptr_q <= sh_q[PTR_W-1:0]; // see RULE4
                              kind_q <= K_DATA;
                           end else begin
                              state_q <= D_WAIT; // see RULE2
                           end
                        end
                        K_DATA: begin
                           sda_oe_q <= 1'b1;
                           wr_stb_q <= 1'b1;
                           wr_addr_q <= ptr_q; // see RULE5
                           wr_data_q <= sh_q;
                           ptr_q <= next_ptr(ptr_q); // see RULE5
                        end
                     endcase
                  end
               end
               D_ACK: begin
                  if (scl_fall) begin // see RULE14
                     if (rw_q && kind_q == K_REG) begin
                        sda_oe_q <= !mem_q[ptr_q][7];
                        sh_q <= {mem_q[ptr_q][6:0], 1'b0};
                        state_q <= D_TX;
                     end else begin
                        sda_oe_q <= 1'b0;
                        state_q <= D_RX;
                     end
                  end
               end
               D_TX: begin
                  if (scl_rise) begin
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall) begin
                     if (cnt_q == BITS_PER_BYTE) begin
                        cnt_q <= 4'h0;
                        sda_oe_q <= 1'b0;
                        state_q <= D_RACK;
                     end else begin
                        sda_oe_q <= !sh_q[7]; // see RULE1
                        sh_q <= {sh_q[6:0], 1'b0};
                     end
                  end
               end
               D_RACK: begin
                  if (scl_rise) begin
                     mack_q <= !sda_s2_q;
                     ptr_q <= next_ptr(ptr_q); // see RULE9
                  end else if (scl_fall) begin
                     if (mack_q) begin
                        sda_oe_q <= !mem_q[ptr_q][7];
                        sh_q <= {mem_q[ptr_q][6:0], 1'b0};
                        state_q <= D_TX;
                     end else begin
                        state_q <= D_WAIT; // see RULE3
                     end
                  end
               end
               default: begin
                  state_q <= D_IDLE;
                  sda_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            mem_q[i] <= REG_RESET;
         end
      end else if (wr_stb_q) begin
         mem_q[wr_addr_q] <= wr_data_q;
      end
   end

   // Data line is only ever pulled low, never driven high
   assign bus.s_sda_o = 1'b0; // see RULE14
   assign bus.s_sda_oe = sda_oe_q;
   assign wr_stb_o = wr_stb_q;
   assign wr_addr_o = wr_addr_q;
   assign wr_data_o = wr_data_q;
   assign busy_o = (state_q != D_IDLE);
endmodule

/* File: twrs_host.sv */
`timescale 1ns/10ps
module twrs_host #(
   parameter int unsigned LEN_W = 4
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   twrs_if.host bus,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_read_i,
   input wire logic [6:0] cmd_dev_addr_i,
   input wire logic [7:0] cmd_reg_i,
   input wire logic [LEN_W-1:0] cmd_len_i,
   input wire logic [7:0] wdata_i,
   output logic wdata_take_o,
   output logic [7:0] rdata_o,
   output logic rdata_valid_o,
   output logic done_o,
   output logic nack_o
);
   import twrs_pkg::*;

   twrs_host_state_t st_q;
   twrs_seq_t seq_q;
   logic [DIV_W-1:0] div_q;
   logic [1:0] qtr_q;
   logic [3:0] bit_q;
   logic [8:0] sh_q;
   logic [8:0] rx_q;
   logic [LEN_W-1:0] left_q;
   logic rd_q;
   logic [6:0] dev_q;
   logic [7:0] reg_q;
   logic scl_oe_q;
   logic sda_oe_q;
   logic sda_s1_q;
   logic sda_s2_q;
   logic done_q;
   logic nack_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic tick;
   logic byte_end;
   logic ack_ok;

   assign tick = (div_q == DIV_W'(QTR_CYC - 1));
   assign byte_end = (st_q == H_BYTE) && tick && (qtr_q == 2'd3) && (bit_q == BITS_PER_BYTE);
   assign ack_ok = !rx_q[0];
   assign wdata_take_o = byte_end && ack_ok &&
      ((seq_q == Q_REG && !rd_q) || (seq_q == Q_WDATA && left_q != LEN_W'(1)));

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
      end else begin
         sda_s1_q <= bus.sda;
         sda_s2_q <= sda_s1_q;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q <= '0;
      end else if (st_q == H_IDLE || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= H_IDLE;
         seq_q <= Q_DEVW;
         qtr_q <= 2'd0;
         bit_q <= 4'h0;
         sh_q <= 9'h1FF;
         rx_q <= 9'h000;
         left_q <= '0;
         rd_q <= 1'b0;
         dev_q <= 7'h00;
         reg_q <= 8'h00;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         done_q <= 1'b0;
         nack_q <= 1'b0;
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         rvalid_q <= 1'b0;
         if (st_q == H_IDLE) begin
            if (cmd_valid_i) begin
               st_q <= H_START;
               seq_q <= Q_DEVW;
               qtr_q <= 2'd0;
               rd_q <= cmd_read_i;
               dev_q <= cmd_dev_addr_i;
               reg_q <= cmd_reg_i;
               left_q <= (cmd_len_i == '0) ? LEN_W'(1) : cmd_len_i;
               nack_q <= 1'b0;
            end
         end else if (tick) begin
            qtr_q <= qtr_q + 2'd1;
            unique case (st_q)
               H_START: begin
                  // Works from idle and, as a repeated start, from clock low
                  unique case (qtr_q)
                     2'd0: sda_oe_q <= 1'b0;
                     2'd1: scl_oe_q <= 1'b0;
                     2'd2: sda_oe_q <= 1'b1;
                     2'd3: begin
                        scl_oe_q <= 1'b1;
                        st_q <= H_BYTE;
                        bit_q <= 4'h0;
                        sh_q <= {dev_q, seq_q == Q_DEVR, 1'b1}; // see RULE12
                     end
                  endcase
               end
               H_BYTE: begin
                  unique case (qtr_q)
                     2'd0: sda_oe_q <= !sh_q[8]; // see RULE1
                     2'd1: scl_oe_q <= 1'b0;
                     2'd2: rx_q <= {rx_q[7:0], sda_s2_q};
                     2'd3: begin
                        scl_oe_q <= 1'b1;
                        sh_q <= {sh_q[7:0], 1'b1};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == BITS_PER_BYTE) begin
                           bit_q <= 4'h0;
                           unique case (seq_q)
                              Q_DEVW: begin
                                 seq_q <= Q_REG;
                                 sh_q <= {reg_q, 1'b1}; // see RULE4
                              end
                              Q_REG: begin
                                 if (rd_q) begin
                                    st_q <= H_START; // see RULE8 RULE11
                                    seq_q <= Q_DEVR;
                                 end else begin
                                    seq_q <= Q_WDATA;
                                    sh_q <= {wdata_i, 1'b1};
                                 end
                              end
                              Q_WDATA: begin
                                 left_q <= left_q - 1'b1;
                                 sh_q <= {wdata_i, 1'b1};
                                 if (left_q == LEN_W'(1)) begin
                                    st_q <= H_STOP;
                                 end
                              end
                              Q_DEVR: begin
                                 seq_q <= Q_RDATA;
                                 sh_q <= {8'hFF, left_q == LEN_W'(1)};
                              end
                              Q_RDATA: begin
                                 rdata_q <= rx_q[8:1];
                                 rvalid_q <= 1'b1;
                                 left_q <= left_q - 1'b1;
                                 sh_q <= {8'hFF, left_q == LEN_W'(2)}; // see RULE3
                                 if (left_q == LEN_W'(1)) begin
                                    st_q <= H_STOP;
                                 end
                              end
                           endcase
                           if (seq_q != Q_RDATA && !ack_ok) begin // see RULE2
                              st_q <= H_STOP;
                              nack_q <= 1'b1;
                           end
                        end
                     end
                  endcase
               end
               H_STOP: begin
                  unique case (qtr_q)
                     2'd0: sda_oe_q <= 1'b1;
                     2'd1: scl_oe_q <= 1'b0;
                     2'd2: sda_oe_q <= 1'b0; // see RULE10
                     2'd3: begin
                        st_q <= H_IDLE;
                        done_q <= 1'b1;
                     end
                  endcase
               end
               default: st_q <= H_IDLE;
            endcase
         end
      end
   end

   assign bus.m_scl_o = 1'b0;
   assign bus.m_scl_oe = scl_oe_q;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_sda_oe = sda_oe_q;
   assign cmd_ready_o = (st_q == H_IDLE);
   assign rdata_o = rdata_q;
   assign rdata_valid_o = rvalid_q;
   assign done_o = done_q;
   assign nack_o = nack_q;
endmodule

/* File: twrs_if.sv */
`timescale 1ns/10ps
interface twrs_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;

   // Open-drain wires with pull-ups: any enabled low driver wins
   assign scl = !(m_scl_oe && !m_scl_o);
   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

   modport host (
      output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
      input scl, sda
   );
   modport dev (
      output s_sda_o, s_sda_oe,
      input scl, sda
   );
endinterface

/* File: twrs_pkg.sv */
package twrs_pkg;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned SCL_PERIOD_NS = 10000;
   // Host splits each serial clock period into four equal quarters
   localparam int unsigned QTR_CYC = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
   localparam int unsigned DIV_W = 8;
   localparam logic [6:0] DEV_ADDR_BASE = 7'h4C;
   localparam logic [7:0] REG_MAX = 8'h1E;
   localparam int unsigned REG_COUNT = 31;
   localparam int unsigned PTR_W = 5;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   typedef enum logic [5:0] {
      D_IDLE = 6'b00_0001,
      D_RX   = 6'b00_0010,
      D_ACK  = 6'b00_0100,
      D_TX   = 6'b00_1000,
      D_RACK = 6'b01_0000,
      D_WAIT = 6'b10_0000
   } twrs_dev_state_t;

   typedef enum logic [2:0] {
      K_ADDR = 3'b001,
      K_REG  = 3'b010,
      K_DATA = 3'b100
   } twrs_kind_t;

   typedef enum logic [3:0] {
      H_IDLE  = 4'b0001,
      H_START = 4'b0010,
      H_BYTE  = 4'b0100,
      H_STOP  = 4'b1000
   } twrs_host_state_t;

   typedef enum logic [4:0] {
      Q_DEVW  = 5'b0_0001,
      Q_REG   = 5'b0_0010,
      Q_WDATA = 5'b0_0100,
      Q_DEVR  = 5'b0_1000,
      Q_RDATA = 5'b1_0000
   } twrs_seq_t;
endpackage
